// ### rtl/rpc_cfg_decode.v
// Capture and decode of the two resistor configuration codes.
`timescale 1ns/1ps
`include "rpc_defs.vh"

module rpc_cfg_decode (
	input wire clk,
	input wire rst,
	input wire clear,
	input wire cap_pair,
	input wire cap_opt,
	input wire [4:0] voltage_pair_resistor_code,
	input wire [3:0] option_resistor_code,
	output wire [9:0] first_output_level,
	output wire [9:0] second_output_level,
	output wire reserved,
	output wire dvs_en,
	output wire latch_mode,
	output wire ilim_high,
	output wire start_second
);

	// Captured codes; reset and clear leave them at reserved values.
	reg [4:0] pair_code_reg;
	reg [3:0] opt_code_reg;
	wire [20:0] pair_word;
	wire [4:0] opt_word;

	// Voltage pair table: valid bit, first level, second level.
	function [20:0] pair_table;
		input [4:0] code;
		begin
			case (code)
				5'h00: pair_table = {1'b1, `RPC_LVL_3V3, `RPC_LVL_3V6};
				5'h01: pair_table = {1'b1, `RPC_LVL_1V8, `RPC_LVL_2V5};
				5'h02: pair_table = {1'b1, `RPC_LVL_1V8, `RPC_LVL_2V8};
				5'h03: pair_table = {1'b1, `RPC_LVL_1V8, `RPC_LVL_3V3};
				5'h04: pair_table = {1'b1, `RPC_LVL_1V8, `RPC_LVL_3V6};
				5'h05: pair_table = {1'b1, `RPC_LVL_2V5, `RPC_LVL_1V8};
				5'h06: pair_table = {1'b1, `RPC_LVL_2V5, `RPC_LVL_2V8};
				5'h07: pair_table = {1'b1, `RPC_LVL_2V5, `RPC_LVL_3V3};
				5'h08: pair_table = {1'b1, `RPC_LVL_2V5, `RPC_LVL_3V6};
				5'h09: pair_table = {1'b1, `RPC_LVL_2V8, `RPC_LVL_1V8};
				5'h0a: pair_table = {1'b1, `RPC_LVL_2V8, `RPC_LVL_2V5};
				5'h0b: pair_table = {1'b1, `RPC_LVL_2V8, `RPC_LVL_3V3};
				5'h0c: pair_table = {1'b1, `RPC_LVL_2V8, `RPC_LVL_3V6};
				5'h0d: pair_table = {1'b1, `RPC_LVL_3V3, `RPC_LVL_1V8};
				5'h0e: pair_table = {1'b1, `RPC_LVL_3V3, `RPC_LVL_2V5};
				5'h0f: pair_table = {1'b1, `RPC_LVL_3V3, `RPC_LVL_2V8};
				5'h10: pair_table = {1'b1, `RPC_LVL_3V3, `RPC_LVL_3V8};
				5'h11: pair_table = {1'b1, `RPC_LVL_3V3, `RPC_LVL_5V0};
				5'h12: pair_table = {1'b1, `RPC_LVL_3V6, `RPC_LVL_2V8};
				5'h13: pair_table = {1'b1, `RPC_LVL_3V6, `RPC_LVL_3V3};
				5'h14: pair_table = {1'b1, `RPC_LVL_3V6, `RPC_LVL_5V0};
				5'h15: pair_table = {1'b1, `RPC_LVL_3V6, `RPC_LVL_5V2};
				5'h16: pair_table = {1'b1, `RPC_LVL_3V8, `RPC_LVL_3V3};
				5'h17: pair_table = {1'b1, `RPC_LVL_3V8, `RPC_LVL_3V6};
				5'h18: pair_table = {1'b1, `RPC_LVL_3V8, `RPC_LVL_5V0};
				5'h19: pair_table = {1'b1, `RPC_LVL_5V0, `RPC_LVL_3V3};
				5'h1a: pair_table = {1'b1, `RPC_LVL_5V2, `RPC_LVL_3V3};
				5'h1b: pair_table = {1'b1, `RPC_LVL_2V1, `RPC_LVL_2V3};
				default: pair_table = 21'h000000;
			endcase
		end
	endfunction

	// Option table: valid, voltage scaling, latch-off, high limit, second at startup.
	function [4:0] opt_table;
		input [3:0] code;
		begin
			case (code)
				4'h0: opt_table = 5'h13;
				4'h1: opt_table = 5'h11;
				4'h2: opt_table = 5'h12;
				4'h3: opt_table = 5'h14;
				4'h4: opt_table = 5'h16;
				4'h5: opt_table = 5'h18;
				4'h6: opt_table = 5'h1a;
				4'h7: opt_table = 5'h1c;
				4'h8: opt_table = 5'h1e;
				default: opt_table = 5'h00;
			endcase
		end
	endfunction

	// Codes are read one after the other during the startup sequence.
	always @(posedge clk)
	begin
		if (rst || clear)
		begin
			pair_code_reg <= `RPC_PAIR_CODE_RST;
			opt_code_reg <= `RPC_OPT_CODE_RST;
		end
		else
		begin
			if (cap_pair)
				pair_code_reg <= voltage_pair_resistor_code;
			if (cap_opt)
				opt_code_reg <= option_resistor_code;
		end
	end

	assign pair_word = pair_table(pair_code_reg);
	assign opt_word = opt_table(opt_code_reg);
	assign first_output_level = pair_word[19:10];
	assign second_output_level = pair_word[9:0];
	assign reserved = !pair_word[20] || !opt_word[4];
	// Starting on the second level forbids scaling and latch-off.
	assign dvs_en = opt_word[3] && !opt_word[0];
	assign latch_mode = opt_word[2] && !opt_word[0];
	assign ilim_high = opt_word[1];
	assign start_second = opt_word[0];

endmodule // rpc_cfg_decode

// ### rtl/rpc_defs.vh
// Constants for the regulator protection and configuration controller.
`ifndef RPC_DEFS_VH
`define RPC_DEFS_VH
// Register byte offsets on the control bus.
`define RPC_CTRL_OFS 8'h00
`define RPC_STATUS_OFS 8'h04
`define RPC_CONFIG_OFS 8'h08
// Control register: software shutdown bit and reset value.
`define RPC_CTRL_SWOFF_BIT 0
`define RPC_CTRL_RST 1'h0
// Configuration register field positions.
`define RPC_CFG_FIRST_LSB 0
`define RPC_CFG_SECOND_LSB 10
`define RPC_CFG_DVS_BIT 20
`define RPC_CFG_LATCH_BIT 21
`define RPC_CFG_ILIM_BIT 22
`define RPC_CFG_START2_BIT 23
`define RPC_CFG_RSVD_BIT 24
// Status register field positions.
`define RPC_ST_STATE_LSB 0
`define RPC_ST_LEVEL2_BIT 16
`define RPC_ST_RAMP_BIT 17
`define RPC_ST_SUSP_BIT 18
`define RPC_ST_DISCH_BIT 19
// Bus response codes.
`define RPC_RESP_OKAY 2'h0
`define RPC_RESP_SLVERR 2'h2
// Clock rate in MHz and startup and protection intervals in microseconds.
`define RPC_CLK_MHZ 250
`define RPC_STARTUP_US 1600
`define RPC_OC_AUTO_US 2000
`define RPC_OC_LATCH_US 4000
`define RPC_HICCUP_US 14000
// Output levels in units of 10 mV.
`define RPC_LVL_1V8 10'h0b4
`define RPC_LVL_2V1 10'h0d2
`define RPC_LVL_2V3 10'h0e6
`define RPC_LVL_2V5 10'h0fa
`define RPC_LVL_2V8 10'h118
`define RPC_LVL_3V3 10'h14a
`define RPC_LVL_3V6 10'h168
`define RPC_LVL_3V8 10'h17c
`define RPC_LVL_5V0 10'h1f4
`define RPC_LVL_5V2 10'h208
// Reset values of the captured resistor codes (both decode as reserved).
`define RPC_PAIR_CODE_RST 5'h1f
`define RPC_OPT_CODE_RST 4'hf
`endif

// ### rtl/rpc_interval_timer.v
// Interval counter used for startup delay, hiccup and overcurrent timing.
`timescale 1ns/1ps

module rpc_interval_timer #(
	parameter W = 22
)(
	input wire clk,
	input wire rst,
	input wire clear,
	input wire run,
	input wire [W-1:0] limit,
	output wire expired
);

	// Elapsed cycles of run since the last clear.
	reg [W-1:0] count_reg;
	// Sticky flag, high once the count has reached the limit.
	reg expired_reg;

	// Counts while run is high and holds at the limit until cleared.
	always @(posedge clk)
	begin
		if (rst || clear)
		begin
			count_reg <= {W{1'b0}};
			expired_reg <= 1'b0;
		end
		else if (run && !expired_reg)
		begin
			if (count_reg == limit)
				expired_reg <= 1'b1;
			else
				count_reg <= count_reg + {{(W-1){1'b0}}, 1'b1};
		end
	end

	assign expired = expired_reg;

endmodule // rpc_interval_timer

// ### rtl/rpc_regulator_ctrl.v
// Sequencing, protection and configuration controller of the buck-boost regulator.
//
// Implementation choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "rpc_defs.vh"

module rpc_regulator_ctrl #(
	parameter AW = 8,
	parameter TW = 22,
	parameter STARTUP_CYCLES = `RPC_STARTUP_US * `RPC_CLK_MHZ,
	parameter OC_AUTO_CYCLES = `RPC_OC_AUTO_US * `RPC_CLK_MHZ,
	parameter OC_LATCH_CYCLES = `RPC_OC_LATCH_US * `RPC_CLK_MHZ,
	parameter HICCUP_CYCLES = `RPC_HICCUP_US * `RPC_CLK_MHZ
)(
	input wire core_clk,
	input wire rst,
	input wire [AW-1:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [AW-1:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire en_pin,
	input wire uv_fall_flag,
	input wire uv_rise_flag,
	input wire ot_rise_flag,
	input wire ot_fall_flag,
	input wire peak_current_flag,
	input wire short_flag,
	input wire cycle_start,
	input wire softstart_done,
	input wire vout_at_target,
	input wire [4:0] voltage_pair_resistor_code,
	input wire [3:0] option_resistor_code,
	input wire option_config_select_pin,
	output reg switching_en,
	output reg discharge_on,
	output reg charge_phase_on,
	output reg discharge_phase_on,
	output reg current_limit_high,
	output reg softstart_active,
	output reg ramp_up_en,
	output reg [9:0] target_level
);

	// One-hot controller states.
	localparam [9:0] S_OFF = 10'h001;
	localparam [9:0] S_RD1 = 10'h002;
	localparam [9:0] S_RD2 = 10'h004;
	localparam [9:0] S_DLY = 10'h008;
	localparam [9:0] S_SOFT = 10'h010;
	localparam [9:0] S_RUN = 10'h020;
	localparam [9:0] S_HIC = 10'h040;
	localparam [9:0] S_LAT = 10'h080;
	localparam [9:0] S_OT = 10'h100;
	localparam [9:0] S_UV = 10'h200;

	// Interval limits widened to 32 bits before slicing to timer width.
	localparam [31:0] STARTUP_W = STARTUP_CYCLES;
	localparam [31:0] OC_AUTO_W = OC_AUTO_CYCLES;
	localparam [31:0] OC_LATCH_W = OC_LATCH_CYCLES;
	localparam [31:0] HICCUP_W = HICCUP_CYCLES;

	// Current and next controller state.
	reg [9:0] state_reg;
	reg [9:0] state_next;
	// Software shutdown request from the control register.
	reg ctrl_swoff_reg;
	// Second level selected, ramp pending and downward suspend.
	reg level2_reg;
	reg ramp_reg;
	reg susp_reg;
	// Captured write address and data of the bus slave.
	reg [AW-1:0] wr_addr_reg;
	reg [31:0] wr_data_reg;
	reg [3:0] wr_strb_reg;
	// Read word for the addressed register.
	reg [31:0] rd_word;
	// Decoded configuration.
	wire [9:0] cfg_first;
	wire [9:0] cfg_second;
	wire cfg_reserved;
	wire cfg_dvs;
	wire cfg_latch;
	wire cfg_ilim;
	wire cfg_start2;
	// Timer controls and results.
	wire seq_clear;
	wire seq_run;
	wire [TW-1:0] seq_limit;
	wire seq_done;
	wire oc_run;
	wire [TW-1:0] oc_limit;
	wire oc_done;
	// Desired level selection and its value.
	wire want2;
	wire [9:0] want_lvl;
	wire [9:0] cur_lvl;
	// Status and configuration words seen by software.
	wire [31:0] status_word;
	wire [31:0] config_word;

	// Picks the first or second output level.
	function [9:0] pick_level;
		input sel;
		input [9:0] first;
		input [9:0] second;
		begin
			pick_level = sel ? second : first;
		end
	endfunction

	// True for an address that maps to one of the three registers.
	function addr_known;
		input [AW-1:0] addr;
		begin
			addr_known = (addr[7:0] == `RPC_CTRL_OFS) || (addr[7:0] == `RPC_STATUS_OFS)
				|| (addr[7:0] == `RPC_CONFIG_OFS);
		end
	endfunction

	// Resistor codes are read in two successive states; lockout clears them.
	rpc_cfg_decode u_cfg (
		.clk(core_clk),
		.rst(rst),
		.clear(state_reg == S_UV),
		.cap_pair(state_reg == S_RD1),
		.cap_opt(state_reg == S_RD2),
		.voltage_pair_resistor_code(voltage_pair_resistor_code),
		.option_resistor_code(option_resistor_code),
		.first_output_level(cfg_first),
		.second_output_level(cfg_second),
		.reserved(cfg_reserved),
		.dvs_en(cfg_dvs),
		.latch_mode(cfg_latch),
		.ilim_high(cfg_ilim),
		.start_second(cfg_start2)
	);

	// Sequence timer: startup delay from the enable edge, or hiccup off-time.
	assign seq_clear = ((state_next == S_RD1) && (state_reg != S_RD1))
		|| ((state_next == S_HIC) && (state_reg != S_HIC));
	assign seq_run = (state_reg == S_RD1) || (state_reg == S_RD2) || (state_reg == S_DLY)
		|| (state_reg == S_HIC);
	assign seq_limit = (state_reg == S_HIC) ? HICCUP_W[TW-1:0] : STARTUP_W[TW-1:0];

	rpc_interval_timer #(
		.W(TW)
	) u_seq_timer (
		.clk(core_clk),
		.rst(rst),
		.clear(seq_clear),
		.run(seq_run),
		.limit(seq_limit),
		.expired(seq_done)
	);

	// Fault timer counts only uninterrupted overcurrent or short after soft-start.
	assign oc_run = (state_reg == S_RUN) && (peak_current_flag || short_flag);
	assign oc_limit = cfg_latch ? OC_LATCH_W[TW-1:0] : OC_AUTO_W[TW-1:0];

	rpc_interval_timer #(
		.W(TW)
	) u_oc_timer (
		.clk(core_clk),
		.rst(rst),
		.clear(!oc_run),
		.run(oc_run),
		.limit(oc_limit),
		.expired(oc_done)
	);

	// Next-state logic; undervoltage outranks enable, enable outranks heat.
	always @*
	begin
		state_next = state_reg;
		if (uv_fall_flag)
			state_next = S_UV;
		else if (state_reg == S_UV)
		begin
			// Stay locked out until the supply is back above the upper threshold.
			if (uv_rise_flag)
				state_next = S_OFF;
		end
		else if (!en_pin || ctrl_swoff_reg)
			state_next = S_OFF;
		// A latched fault ignores heat so that cooling cannot undo the latch.
		else if (ot_rise_flag && (state_reg != S_OT) && (state_reg != S_LAT))
			state_next = S_OT;
		else
		begin
			case (state_reg)
				// Enable high with supply good: bias up and read codes.
				S_OFF: state_next = S_RD1;
				S_RD1: state_next = S_RD2;
				S_RD2: state_next = S_DLY;
				// Hold off soft-start until the delay from the enable edge ends.
				S_DLY:
				begin
					if (cfg_reserved)
						state_next = S_LAT;
					else if (seq_done)
						state_next = S_SOFT;
				end
				S_SOFT:
				begin
					if (softstart_done)
						state_next = S_RUN;
				end
				// Sustained overcurrent either latches off or starts a hiccup.
				S_RUN:
				begin
					if (oc_done)
						state_next = cfg_latch ? S_LAT : S_HIC;
				end
				S_HIC:
				begin
					if (seq_done)
						state_next = S_SOFT;
				end
				// Latched: only enable low, software shutdown or lockout leaves this state.
				S_LAT: state_next = S_LAT;
				S_OT:
				begin
					if (ot_fall_flag)
						state_next = S_RD1;
				end
				default: state_next = S_OFF;
			endcase
		end
	end

	// State register.
	always @(posedge core_clk)
	begin
		if (rst)
			state_reg <= S_OFF;
		else
			state_reg <= state_next;
	end

	// Voltage selection: startup level before run, select pin afterwards.
	assign want2 = cfg_dvs ? option_config_select_pin : cfg_start2;
	assign want_lvl = pick_level(want2, cfg_first, cfg_second);
	assign cur_lvl = pick_level(level2_reg, cfg_first, cfg_second);

	// Level tracking with ramp on rise and suspend on fall.
	always @(posedge core_clk)
	begin
		if (rst || (state_reg == S_UV))
		begin
			level2_reg <= 1'b0;
			ramp_reg <= 1'b0;
			susp_reg <= 1'b0;
			target_level <= 10'h000;
		end
		else if (state_reg != S_RUN)
		begin
			// Pin is ignored until soft-start ends; the ramp covers soft-start.
			level2_reg <= cfg_start2;
			target_level <= pick_level(cfg_start2, cfg_first, cfg_second);
			ramp_reg <= (state_reg == S_SOFT);
			susp_reg <= 1'b0;
		end
		else if (want2 != level2_reg)
		begin
			level2_reg <= want2;
			target_level <= want_lvl;
			// Rising change ramps; falling change steps and waits for decay.
			ramp_reg <= (want_lvl > cur_lvl);
			susp_reg <= !(want_lvl > cur_lvl);
		end
		else if (vout_at_target)
		begin
			ramp_reg <= 1'b0;
			susp_reg <= 1'b0;
		end
	end

	// Power-stage controls, all registered; switching, discharge and soft-start follow the next state.
	always @(posedge core_clk)
	begin
		if (rst)
		begin
			switching_en <= 1'b0;
			discharge_on <= 1'b1;
			current_limit_high <= 1'b0;
			softstart_active <= 1'b0;
			ramp_up_en <= 1'b0;
		end
		else
		begin
			switching_en <= ((state_next == S_SOFT) || (state_next == S_RUN)) && !susp_reg;
			discharge_on <= (state_next == S_OFF) || (state_next == S_UV);
			current_limit_high <= cfg_ilim;
			softstart_active <= (state_next == S_SOFT);
			ramp_up_en <= ramp_reg;
		end
	end

	// Cycle-by-cycle limit: peak current ends charging for the rest of the cycle.
	always @(posedge core_clk)
	begin
		if (rst || !switching_en)
		begin
			charge_phase_on <= 1'b0;
			discharge_phase_on <= 1'b0;
		end
		else if (charge_phase_on && peak_current_flag)
		begin
			charge_phase_on <= 1'b0;
			discharge_phase_on <= 1'b1;
		end
		else if (cycle_start)
		begin
			charge_phase_on <= 1'b1;
			discharge_phase_on <= 1'b0;
		end
	end

	// Software-visible words.
	assign status_word = {12'h000, discharge_on, susp_reg, ramp_reg, level2_reg, 6'h00, state_reg};
	assign config_word = {7'h00, cfg_reserved, cfg_start2, cfg_ilim, cfg_latch, cfg_dvs,
		cfg_second, cfg_first};

	// Read multiplexer; unmapped addresses read as zero.
	always @*
	begin
		case (s_axi_araddr[7:0])
			`RPC_CTRL_OFS: rd_word = {31'h00000000, ctrl_swoff_reg};
			`RPC_STATUS_OFS: rd_word = status_word;
			`RPC_CONFIG_OFS: rd_word = config_word;
			default: rd_word = 32'h00000000;
		endcase
	end

	// Write path: address and data are taken in either order, then answered.
	always @(posedge core_clk)
	begin
		if (rst)
		begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RPC_RESP_OKAY;
			wr_addr_reg <= {AW{1'b0}};
			wr_data_reg <= 32'h00000000;
			wr_strb_reg <= 4'h0;
			ctrl_swoff_reg <= `RPC_CTRL_RST;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				wr_addr_reg <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				wr_data_reg <= s_axi_wdata;
				wr_strb_reg <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			// Both halves held: commit the write and raise the response.
			if (!s_axi_awready && !s_axi_wready && !s_axi_bvalid)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= addr_known(wr_addr_reg) ? `RPC_RESP_OKAY : `RPC_RESP_SLVERR;
				if ((wr_addr_reg[7:0] == `RPC_CTRL_OFS) && wr_strb_reg[0])
					ctrl_swoff_reg <= wr_data_reg[`RPC_CTRL_SWOFF_BIT];
			end
			// Response taken: accept the next write.
			if (s_axi_bvalid && s_axi_bready)
			begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
			// Lockout resets the software shutdown along with the other state.
			if (state_reg == S_UV)
				ctrl_swoff_reg <= `RPC_CTRL_RST;
		end
	end

	// Read path: one outstanding read, data registered with the response.
	always @(posedge core_clk)
	begin
		if (rst)
		begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `RPC_RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_word;
			s_axi_rresp <= addr_known(s_axi_araddr) ? `RPC_RESP_OKAY : `RPC_RESP_SLVERR;
		end
		else if (s_axi_rvalid && s_axi_rready)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

endmodule // rpc_regulator_ctrl

// ### sim/rpc_ctrl_monitor.sv
// Port checker for the regulator protection and configuration controller.
`timescale 1ns/1ps

module rpc_ctrl_monitor (
	input wire core_clk,
	input wire rst,
	input wire en_pin,
	input wire uv_fall_flag,
	input wire uv_rise_flag,
	input wire ot_rise_flag,
	input wire peak_current_flag,
	input wire cycle_start,
	input wire softstart_active,
	input wire switching_en,
	input wire discharge_on,
	input wire charge_phase_on,
	input wire discharge_phase_on,
	input wire ramp_up_en,
	input wire [9:0] target_level
);
	// All checks sample on the core clock and rest while reset is held.
	default clocking mon_cb @(posedge core_clk);
	endclocking
	default disable iff (rst);

	uv_off_a: assert property (uv_fall_flag |-> ##[1:2]
		(!switching_en && discharge_on && target_level == 10'h0))
		else $error("undervoltage left the regulator on");
	en_off_a: assert property (!en_pin |-> ##[1:2] (!switching_en && discharge_on))
		else $error("enable low left the regulator on");
	ot_off_a: assert property (ot_rise_flag |-> ##[1:2] !switching_en)
		else $error("overtemperature left the regulator on");
	supply_gate_a: assert property ($rose(switching_en) |-> $past(uv_rise_flag))
		else $error("switching started without supply");
	peak_cut_a: assert property (charge_phase_on && peak_current_flag && switching_en && !cycle_start
		|=> !charge_phase_on && discharge_phase_on)
		else $error("peak current did not end charging");
	disch_excl_a: assert property (!(discharge_on && switching_en))
		else $error("discharge closed while switching");
	step_down_a: assert property (target_level != 10'h0 && target_level < $past(target_level)
		|=> !switching_en && !ramp_up_en)
		else $error("lowering did not suspend switching");
	ramp_up_a: assert property ($past(target_level) != 10'h0
		&& $past(switching_en) && target_level > $past(target_level) |=> ramp_up_en)
		else $error("raising did not ramp");
	ss_hold_a: assert property (softstart_active && $past(softstart_active)
		|-> $stable(target_level))
		else $error("target moved during soft-start");
endmodule // rpc_ctrl_monitor

// ### sim/rpc_host_gpio.sv
// Host GPIO model driving the enable pin and the voltage select pin.
`timescale 1ns/1ps

module rpc_host_gpio (
	input wire core_clk,
	input wire en_req,
	input wire sel_req,
	input wire softstart_done,
	output logic en_pin = 1'b0,
	output logic option_config_select_pin = 1'b0
);
	logic armed_reg = 1'b0; // Set once soft-start has finished since enable.

	// The select pin floats before soft-start; the config resistor pulls it low.
	always @(posedge core_clk)
	begin
		en_pin <= en_req;
		armed_reg <= en_req & (armed_reg | softstart_done);
		option_config_select_pin <= armed_reg & sel_req;
	end
endmodule // rpc_host_gpio

// ### sim/tb_top.sv
// Self-checking bench for the regulator protection and configuration controller.
`timescale 1ns/1ps

module tb_top;
	localparam int SU = 40, OA = 20, OL = 40, HC = 60;
	localparam string PAIRS = "56030405063034353640434546505354575864656869757678859512";
	localparam logic [35:0] OPTS = 36'h73516248c; // Per option code: start2, ilim, latch, dvs.
	logic [9:0] lv [10] = '{10'h0b4, 10'h0d2, 10'h0e6, 10'h0fa, 10'h118,
		10'h14a, 10'h168, 10'h17c, 10'h1f4, 10'h208};
	logic core_clk = 1'b0, rst = 1'b1;
	logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
	logic [3:0] s_axi_wstrb = 4'h0, oc = 4'h0, c, o;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic en_req = 1'b0, sel_req = 1'b0, en_pin, option_config_select_pin;
	logic uv_fall_flag = 1'b0, uv_rise_flag = 1'b1, ot_rise_flag = 1'b0, ot_fall_flag = 1'b1;
	logic peak_current_flag = 1'b0, short_flag = 1'b0, cycle_start = 1'b0;
	logic softstart_done = 1'b0, vout_at_target = 1'b1;
	logic [4:0] pc = 5'h0, p;
	logic switching_en, discharge_on, charge_phase_on, discharge_phase_on;
	logic current_limit_high, softstart_active, ramp_up_en;
	logic [9:0] target_level, f, s;
	int mismatches = 0, check_count = 0;

	rpc_regulator_ctrl #(.STARTUP_CYCLES(SU), .OC_AUTO_CYCLES(OA), .OC_LATCH_CYCLES(OL),
		.HICCUP_CYCLES(HC)) u_rpc_regulator_ctrl (.core_clk, .rst, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .en_pin, .uv_fall_flag, .uv_rise_flag, .ot_rise_flag, .ot_fall_flag,
		.peak_current_flag, .short_flag, .cycle_start, .softstart_done, .vout_at_target,
		.voltage_pair_resistor_code(pc), .option_resistor_code(oc), .option_config_select_pin,
		.switching_en, .discharge_on, .charge_phase_on, .discharge_phase_on,
		.current_limit_high, .softstart_active, .ramp_up_en, .target_level);
	rpc_host_gpio u_rpc_host_gpio (.core_clk, .en_req, .sel_req, .softstart_done, .en_pin,
		.option_config_select_pin);

	// Free-running core clock at 250 MHz.
	always #2 core_clk = ~core_clk;

	// Output level k of pair code n, from the pair table above.
	function automatic logic [9:0] lvl(input int n, input int k);
		return lv[PAIRS[2 * n + k] - 8'h30];
	endfunction

	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
	endtask

	// Compares and counts; any difference is reported at once.
	task automatic chk(input logic [33:0] got, input logic [33:0] exp);
		check_count++;
		if (got !== exp)
		begin
			mismatches++;
			$display("Error at %0t: got %h want %h", $time, got, exp);
		end
	endtask

	// Bus write; a missing response comes back as code 3.
	task automatic axw(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
		int n;
		n = 0;
		@(posedge core_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_wstrb <= 4'hf;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge core_clk);
			n++;
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end
		while (!s_axi_bvalid && n < 99);
		rs = s_axi_bvalid ? s_axi_bresp : 2'h3;
		s_axi_bready <= 1'b0;
	endtask

	// Bus read; a missing response comes back as code 3.
	task automatic axr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
		int n;
		n = 0;
		@(posedge core_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge core_clk);
			n++;
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end
		while (!s_axi_rvalid && n < 99);
		v = s_axi_rdata;
		rs = s_axi_rvalid ? s_axi_rresp : 2'h3;
		s_axi_rready <= 1'b0;
	endtask

	// Enables from off and waits for soft-start, which must not come early.
	task automatic boot(input logic ok);
		int n;
		n = 0;
		softstart_done <= 1'b0;
		en_req <= 1'b1;
		while (!softstart_active && n < SU + 30)
		begin
			@(posedge core_clk);
			n++;
		end
		chk({softstart_active, n > SU}, {ok, 1'b1});
		softstart_done <= 1'b1;
		cyc(4);
	endtask

	// One select change; a rise ramps, a fall suspends switching until decayed.
	task automatic dvs_step(input logic sl, input logic [9:0] lt, input logic up);
		vout_at_target <= 1'b0;
		sel_req <= sl;
		cyc(5);
		chk({target_level, ramp_up_en, switching_en}, {lt, up, up});
		vout_at_target <= 1'b1;
		cyc(3);
		chk({ramp_up_en, switching_en}, 2'b01);
	endtask

	task automatic complete_run();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	initial
	begin
		void'($urandom(69667));
		cyc(5);
		rst <= 1'b0;
		cyc(1);
		chk({switching_en, discharge_on, target_level}, {2'b01, 10'h0});
		axr(8'h40, d, r);
		chk({r, d}, {2'h2, 32'h0});
		axw(8'h44, 32'h1, r);
		chk(r, 2'h2);
		$display("bus test done");
		for (int i = 0; i < 10; i++)
		begin
			p = (i < 9) ? 5'($urandom % 28) : 5'(28 + $urandom % 4);
			c = (i < 9) ? 4'(i) : 4'($urandom % 9);
			o = OPTS[4 * c +: 4];
			f = lvl(p, 0);
			s = lvl(p, 1);
			pc <= p;
			oc <= c;
			boot(i < 9);
			axr(8'h08, d, r);
			if (i == 9) chk(d[24], 1'b1);
			else
			begin
				chk(d, {8'h0, o, s, f});
				chk({current_limit_high, target_level}, {o[2], o[3] ? s : f});
				if (o[0])
				begin
					dvs_step(1'b1, s, s > f);
					dvs_step(1'b0, f, f > s);
				end
				else
				begin
					sel_req <= 1'b1;
					cyc(5);
					chk(target_level, o[3] ? s : f);
					sel_req <= 1'b0;
				end
				cycle_start <= 1'b1;
				cyc(1);
				cycle_start <= 1'b0;
				cyc(2);
				chk(charge_phase_on, 1'b1);
				peak_current_flag <= !i[0];
				short_flag <= i[0];
				cyc(2);
				if (!i[0]) chk({charge_phase_on, discharge_phase_on}, 2'b01);
				cyc((o[1] ? OL : OA) - 4);
				chk(switching_en, 1'b1);
				cyc(10);
				chk(switching_en, 1'b0);
				peak_current_flag <= 1'b0;
				short_flag <= 1'b0;
				cyc(HC - 12);
				chk(switching_en, 1'b0);
				cyc(30);
				chk(switching_en, !o[1]);
			end
			en_req <= 1'b0;
			cyc(4);
			chk({switching_en, discharge_on}, 2'b01);
			$display("startup test %0d done", i);
		end
		pc <= 5'h0;
		oc <= 4'h2;
		boot(1'b1);
		ot_fall_flag <= 1'b0;
		ot_rise_flag <= 1'b1;
		cyc(3);
		chk(switching_en, 1'b0);
		ot_rise_flag <= 1'b0;
		cyc(20);
		chk(switching_en, 1'b0);
		ot_fall_flag <= 1'b1;
		cyc(SU + 30);
		chk(switching_en, 1'b1);
		axw(8'h00, 32'h1, r);
		cyc(3);
		chk({r, switching_en}, 3'b000);
		axr(8'h00, d, r);
		chk(d, 32'h1);
		uv_rise_flag <= 1'b0;
		uv_fall_flag <= 1'b1;
		cyc(3);
		chk({switching_en, discharge_on, target_level}, {2'b01, 10'h0});
		uv_fall_flag <= 1'b0;
		cyc(SU + 30);
		chk(switching_en, 1'b0);
		uv_rise_flag <= 1'b1;
		cyc(SU + 30);
		chk(switching_en, 1'b1);
		$display("protection test done");
		complete_run();
	end

	// Watchdog well beyond the expected run length.
	initial
	begin
		#60000;
		mismatches++;
		complete_run();
	end
endmodule // tb_top

bind rpc_regulator_ctrl rpc_ctrl_monitor u_rpc_ctrl_monitor (.core_clk, .rst, .en_pin,
	.uv_fall_flag, .uv_rise_flag, .ot_rise_flag, .peak_current_flag, .cycle_start,
	.softstart_active, .switching_en, .discharge_on, .charge_phase_on, .discharge_phase_on,
	.ramp_up_en, .target_level);
